// [design/rsco_pkg.sv]
// Constants shared by the rheostat serial control ends.
// Assumes both ends are built from this package and one system clock.
package rsco_pkg;
   localparam int FRAME_BITS = 16;
   localparam int DATA_W = 10;
   localparam int CMD_LSB = 10;
   localparam int CMD_W = 4;
   localparam int ADDR_W = 6;
   localparam int CTRL_W = 3;
   localparam int CNT_W = 6;
   // Control bit positions
   localparam int CB_PROG = 0;
   localparam int CB_UNLOCK = 1;
   localparam int CB_CALDIS = 2;
   // Command codes
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WR_WIPER = 4'h1;
   localparam logic [3:0] CMD_RD_WIPER = 4'h2;
   localparam logic [3:0] CMD_STORE = 4'h3;
   localparam logic [3:0] CMD_SW_RESET = 4'h4;
   localparam logic [3:0] CMD_RD_OTP = 4'h5;
   localparam logic [3:0] CMD_RD_LAST = 4'h6;
   localparam logic [3:0] CMD_WR_CTRL = 4'h7;
   localparam logic [3:0] CMD_RD_CTRL = 4'h8;
   localparam logic [15:0] FLOAT_WORD = 16'h8001;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [5:0] OTP_FIRST_ADDR = 6'h01;
   // Host register map, byte addresses
   localparam logic [3:0] HR_TX = 4'h0;
   localparam logic [3:0] HR_RX = 4'h4;
   localparam logic [3:0] HR_STATUS = 4'h8;
   localparam logic [3:0] HR_HALFDIV = 4'hC;
   // Serial clock timing for the host
   localparam int CLK_NS = 20;
   localparam int SCLK_PERIOD_NS = 160;
   localparam int HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_NS);
   localparam int MIN_HALF_CYC = 4;
   localparam int HALF_W = 8;
   typedef enum logic [1:0] {PRE_MID, PRE_LOAD, PRE_RUN} rsco_preset_e;
   typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_HIGH, HS_LOW, HS_TAIL} rsco_hstate_e;
endpackage

// [design/rsco_if.sv]
// Serial link between host controller and rheostat device.
// The serial output is open drain; the pull-up is resolved here.
`timescale 1ns/1ns
`default_nettype none
interface rsco_if;
   logic syncN;
   logic sclk;
   logic din;
   logic sdoOut;
   logic sdoOeN;
   wire logic sdoLine;
   // Pulled high unless the device pulls low
   assign sdoLine = sdoOeN ? 1'b1 : sdoOut;
   modport dev (input syncN, input sclk, input din, output sdoOut, output sdoOeN);
   modport host (output syncN, output sclk, output din, input sdoLine);
endinterface
`default_nettype wire

// [design/rsco_device.sv]
// Rheostat device end: serial shift register, command decode,
// control flags, wiper register and one-time-programmable store.
// Assumes link pins are asynchronous to ref_clk and slow beside it.
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Fuse store only with program enable set
// - Wiper writes only when unlocked, else frozen
// - Locked and never programmed gives midscale
// - Calibration on unless disable bit set
// - Success flag reflects last store result
// - OTP read uses six-bit address one-based
// - Read commands return wiper, stored value, store count or control
// - Serial output changes on clock rising edge
// - Float word then no-op floats output
// - Daisy chain passes first bits downstream
// - Host keeps select low whole chain
// - Command executes at select rising edge
// - Host may slow clock for chains
// - Wiper value selects one tap position
// - Power-on loads midscale then stored value
// - Four-bit command above ten data bits
// - Read result appears in next frame
// - Software reset reloads stored or midscale
// - Host unlocks control before write or store
module rsco_device import rsco_pkg::*; #(
   parameter int WIPER_W = 10,
   parameter int OTP_DEPTH = 50
) (
   input wire logic ref_clk,
   input wire logic rst,
   rsco_if.dev link,
   input wire logic keepOtp,
   output logic [WIPER_W-1:0] tapSel,
   output logic calEnable,
   output logic otpProgramEnable
);
   if (!(WIPER_W == 10 || WIPER_W == 8) || OTP_DEPTH < 1 || OTP_DEPTH > 63) begin : g_chk
      $error("rsco_device: unsupported WIPER_W or OTP_DEPTH");
   end

   localparam logic [WIPER_W-1:0] MIDSCALE = WIPER_W'(1) << (WIPER_W - 1);
   localparam logic [CNT_W-1:0] OTP_LAST = CNT_W'(OTP_DEPTH);

   logic [2:0] pinS1, pinS2, pinS3;
   logic [15:0] sr, next_sr;
   logic [15:0] outWord, next_outWord;
   logic sdoBit, next_sdoBit;
   logic sdoOeN, next_sdoOeN;
   logic hiZ, next_hiZ;
   logic prevFloat, next_prevFloat;
   logic [CNT_W-1:0] bitCnt, next_bitCnt;
   logic [CTRL_W-1:0] ctrl, next_ctrl;
   logic fuseOk, next_fuseOk;
   logic [WIPER_W-1:0] wiperReg, next_wiperReg;
   logic [CNT_W-1:0] progCount, next_progCount;
   rsco_preset_e preset, next_preset;
   logic [WIPER_W-1:0] otpMem [OTP_DEPTH];
   logic otpWrite;

   logic sclkRise, sclkFall, frameStart, frameEnd;
   logic [CMD_W-1:0] cmd;
   logic [DATA_W-1:0] data;
   logic [ADDR_W-1:0] rdAddr;
   logic [WIPER_W-1:0] storedValue, effWiper, dataWiper, otpRead;

   assign sclkRise = pinS2[1] & ~pinS3[1];
   assign sclkFall = ~pinS2[1] & pinS3[1];
   assign frameStart = ~pinS2[2] & pinS3[2];
   assign frameEnd = pinS2[2] & ~pinS3[2];
   assign cmd = sr[CMD_LSB +: CMD_W];
   assign data = sr[DATA_W-1:0];
   assign rdAddr = data[ADDR_W-1:0];
   // Narrow variant drops the two low data bits
   assign dataWiper = WIPER_W'(data >> (DATA_W - WIPER_W));

   always_comb begin
      if (progCount == '0) begin
         storedValue = MIDSCALE;
      end else begin
         storedValue = otpMem[progCount - CNT_W'(1)];
      end
   end

   // Locked wiper follows the store, midscale when blank
   assign effWiper = ctrl[CB_UNLOCK] ? wiperReg : storedValue;

   always_comb begin
      // Unprogrammed and reserved locations read as zero
      if (rdAddr >= OTP_FIRST_ADDR && rdAddr <= progCount) begin
         otpRead = otpMem[rdAddr - ADDR_W'(1)];
      end else begin
         otpRead = '0;
      end
   end

   function automatic logic [15:0] align(input logic [WIPER_W-1:0] w);
      align = 16'(DATA_W'(w) << (DATA_W - WIPER_W));
   endfunction

   always_comb begin
      next_sr = sr;
      next_outWord = outWord;
      next_sdoBit = sdoBit;
      next_sdoOeN = sdoOeN;
      next_hiZ = hiZ;
      next_prevFloat = prevFloat;
      next_bitCnt = bitCnt;
      next_ctrl = ctrl;
      next_fuseOk = fuseOk;
      next_wiperReg = wiperReg;
      next_progCount = progCount;
      next_preset = preset;
      otpWrite = 1'b0;
      case (preset)
         PRE_MID: begin
            next_wiperReg = MIDSCALE;
            next_preset = PRE_LOAD;
         end
         PRE_LOAD: begin
            next_wiperReg = storedValue;
            next_preset = PRE_RUN;
         end
         PRE_RUN: begin
            if (frameStart) begin
               next_sr = outWord;
               next_bitCnt = '0;
            end else if (pinS2[2] == 1'b0) begin
               if (sclkRise) begin
                  next_sdoBit = sr[15];
                  next_sdoOeN = hiZ | sr[15];
               end
               if (sclkFall) begin
                  next_sr = {sr[14:0], pinS2[0]};
                  if (bitCnt != '1) begin
                     next_bitCnt = bitCnt + CNT_W'(1);
                  end
               end
            end
            // Short frames are dropped whole
            if (frameEnd && bitCnt >= CNT_W'(FRAME_BITS)) begin
               next_outWord = sr;
               next_prevFloat = (sr == FLOAT_WORD);
               if (sr[15:14] == 2'b00) begin
                  case (cmd)
                     CMD_NOP: begin
                        if (prevFloat) begin
                           next_hiZ = 1'b1;
                        end
                     end
                     CMD_WR_WIPER: begin
                        if (ctrl[CB_UNLOCK]) begin
                           next_wiperReg = dataWiper;
                        end
                     end
                     CMD_RD_WIPER: next_outWord = align(effWiper);
                     CMD_STORE: begin
                        if (ctrl[CB_PROG] && progCount < OTP_LAST) begin
                           otpWrite = 1'b1;
                           next_progCount = progCount + CNT_W'(1);
                           next_fuseOk = 1'b1;
                        end else begin
                           next_fuseOk = 1'b0;
                        end
                     end
                     CMD_SW_RESET: next_wiperReg = storedValue;
                     CMD_RD_OTP: next_outWord = align(otpRead);
                     CMD_RD_LAST: next_outWord = 16'(progCount);
                     CMD_WR_CTRL: next_ctrl = data[CTRL_W-1:0];
                     CMD_RD_CTRL: next_outWord = 16'({fuseOk, ctrl});
                     default: next_outWord = sr;
                  endcase
                  if (cmd != CMD_NOP) begin
                     next_hiZ = 1'b0;
                  end
               end else if (sr != FLOAT_WORD) begin
                  next_hiZ = 1'b0;
               end
            end
            if (next_hiZ) begin
               next_sdoOeN = 1'b1;
            end
         end
         default: next_preset = PRE_MID;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      pinS1 <= {link.syncN, link.sclk, link.din};
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      // A reset landing on a frame end must not burn a location
      if (otpWrite && !rst) begin
         otpMem[progCount] <= effWiper;
      end
      if (rst) begin
         sr <= '0;
         outWord <= '0;
         sdoBit <= 1'b1;
         sdoOeN <= 1'b1;
         hiZ <= 1'b0;
         prevFloat <= 1'b0;
         bitCnt <= '0;
         ctrl <= CTRL_RESET;
         fuseOk <= 1'b0;
         wiperReg <= MIDSCALE;
         preset <= PRE_MID;
         if (!keepOtp) begin
            progCount <= '0;
         end
      end else begin
         sr <= next_sr;
         outWord <= next_outWord;
         sdoBit <= next_sdoBit;
         sdoOeN <= next_sdoOeN;
         hiZ <= next_hiZ;
         prevFloat <= next_prevFloat;
         bitCnt <= next_bitCnt;
         ctrl <= next_ctrl;
         fuseOk <= next_fuseOk;
         wiperReg <= next_wiperReg;
         progCount <= next_progCount;
         preset <= next_preset;
      end
   end

   assign link.sdoOut = sdoBit;
   assign link.sdoOeN = sdoOeN;
   assign tapSel = effWiper;
   assign calEnable = ~ctrl[CB_CALDIS];
   assign otpProgramEnable = ctrl[CB_PROG];
endmodule
`default_nettype wire

// [design/rsco_host.sv]
// Host serial controller: classic Wishbone slave on one side,
// frame select, serial clock and data toward the device chain.
// Assumes the serial output returns asynchronously and is synchronised.
`timescale 1ns/1ns
`default_nettype none
module rsco_host import rsco_pkg::*; #(
   parameter int CHAIN_LEN = 1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   rsco_if.host link
);
   if (CHAIN_LEN < 1 || CHAIN_LEN > 2) begin : g_chk
      $error("rsco_host: CHAIN_LEN must be 1 or 2");
   end
   localparam int NBITS = FRAME_BITS * CHAIN_LEN;
   localparam logic [5:0] LAST_BIT = 6'(NBITS - 1);
   localparam logic [HALF_W-1:0] HALF_RESET = HALF_W'(HALF_CYC);
   localparam logic [HALF_W-1:0] HALF_MIN = HALF_W'(MIN_HALF_CYC);

   rsco_hstate_e state, next_state;
   logic [31:0] txShift, next_txShift, rxShift, next_rxShift, rxData, next_rxData;
   logic [HALF_W-1:0] halfDiv, next_halfDiv, divCnt, next_divCnt;
   logic [5:0] bitIdx, next_bitIdx;
   logic syncN, next_syncN, sclk, next_sclk, din, next_din;
   logic ack, next_ack;
   logic [31:0] rdData, next_rdData;
   logic sdoS1, sdoS2;
   logic req, wrReq, tick;

   assign req = cyc_i & stb_i & ~ack;
   assign wrReq = req & we_i & (&sel_i);
   assign tick = (divCnt == '0);

   always_comb begin
      next_state = state;
      next_txShift = txShift;
      next_rxShift = rxShift;
      next_rxData = rxData;
      next_halfDiv = halfDiv;
      // Reload one short so each half lasts exactly halfDiv clocks
      next_divCnt = tick ? halfDiv - HALF_W'(1) : divCnt - HALF_W'(1);
      next_bitIdx = bitIdx;
      next_syncN = syncN;
      next_sclk = sclk;
      next_din = din;
      next_ack = req;
      next_rdData = '0;
      if (req && !we_i) begin
         case (adr_i)
            HR_RX: next_rdData = rxData;
            HR_STATUS: next_rdData = 32'(state != HS_IDLE);
            HR_HALFDIV: next_rdData = 32'(halfDiv);
            default: next_rdData = '0;
         endcase
      end
      // Slower clock eases open-drain chain delay
      if (wrReq && adr_i == HR_HALFDIV) begin
         next_halfDiv = (dat_i[HALF_W-1:0] < HALF_MIN) ? HALF_MIN : dat_i[HALF_W-1:0];
      end
      case (state)
         HS_IDLE: begin
            if (wrReq && adr_i == HR_TX) begin
               next_txShift = dat_i << (32 - NBITS);
               next_syncN = 1'b0;
               next_bitIdx = '0;
               next_divCnt = halfDiv - HALF_W'(1);
               next_state = HS_LEAD;
            end
         end
         HS_LEAD: begin
            if (tick) begin
               next_sclk = 1'b1;
               next_din = txShift[31];
               next_txShift = txShift << 1;
               next_state = HS_HIGH;
            end
         end
         HS_HIGH: begin
            if (tick) begin
               next_sclk = 1'b0;
               next_state = HS_LOW;
            end
         end
         HS_LOW: begin
            if (tick) begin
               next_rxShift = {rxShift[30:0], sdoS2};
               next_bitIdx = bitIdx + 6'(1);
               if (bitIdx == LAST_BIT) begin
                  next_syncN = 1'b1;
                  next_state = HS_TAIL;
               end else begin
                  next_sclk = 1'b1;
                  next_din = txShift[31];
                  next_txShift = txShift << 1;
                  next_state = HS_HIGH;
               end
            end
         end
         HS_TAIL: begin
            if (tick) begin
               next_rxData = rxShift;
               next_state = HS_IDLE;
            end
         end
         default: next_state = HS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      sdoS1 <= link.sdoLine;
      sdoS2 <= sdoS1;
      if (rst) begin
         state <= HS_IDLE;
         txShift <= '0;
         rxShift <= '0;
         rxData <= '0;
         halfDiv <= HALF_RESET;
         divCnt <= '0;
         bitIdx <= '0;
         syncN <= 1'b1;
         sclk <= 1'b0;
         din <= 1'b0;
         ack <= 1'b0;
         rdData <= '0;
      end else begin
         state <= next_state;
         txShift <= next_txShift;
         rxShift <= next_rxShift;
         rxData <= next_rxData;
         halfDiv <= next_halfDiv;
         divCnt <= next_divCnt;
         bitIdx <= next_bitIdx;
         syncN <= next_syncN;
         sclk <= next_sclk;
         din <= next_din;
         ack <= next_ack;
         rdData <= next_rdData;
      end
   end

   assign link.syncN = syncN;
   assign link.sclk = sclk;
   assign link.din = din;
   assign ack_o = ack;
   assign dat_o = rdData;
endmodule
`default_nettype wire

// [verification/rsco_chk.sv]
// Checker for the serial link joining the host and device ends.
// Takes the interface signals as plain inputs; one ref_clk domain.
`timescale 1ns/1ns
`default_nettype none
module rsco_chk #(
   parameter int CHAIN_LEN = 1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic syncN,
   input wire logic sclk,
   input wire logic din,
   input wire logic sdoOut,
   input wire logic sdoOeN
);
   logic sclkQ;
   logic [7:0] riseCnt;
   logic [7:0] sinceRise;
   logic [7:0] next_riseCnt;
   logic [7:0] next_sinceRise;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // Saturates so a long idle never wraps into the legal window
   always_comb begin
      next_sinceRise = (sinceRise == 8'hFF) ? sinceRise : sinceRise + 8'h01;
      next_riseCnt = syncN ? 8'h00 : riseCnt;
      if (sclk && !sclkQ) begin
         next_sinceRise = 8'h00;
         next_riseCnt = riseCnt + 8'h01;
      end
   end
   always_ff @(posedge ref_clk) begin
      sclkQ <= sclk;
      sinceRise <= next_sinceRise;
      riseCnt <= next_riseCnt;
   end
   property p_frame_len;
      $rose(syncN) |-> riseCnt == 8'(16 * CHAIN_LEN);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame bit count wrong");
   property p_clk_in_frame;
      $rose(sclk) |-> !syncN;
   endproperty
   a_clk_in_frame: assert property (p_clk_in_frame) else $error("clock outside frame");
   property p_lead;
      $fell(syncN) |-> !sclk [*4] ##1 sclk;
   endproperty
   a_lead: assert property (p_lead) else $error("lead phase wrong");
   property p_end;
      $rose(syncN) |-> !sclk && !$past(sclk, 4);
   endproperty
   a_end: assert property (p_end) else $error("select rose too early");
   property p_half;
      $rose(sclk) |-> sclk [*4] ##1 !sclk;
   endproperty
   a_half: assert property (p_half) else $error("clock high phase wrong");
   property p_din_hold;
      sclk && $past(sclk) |-> $stable(din);
   endproperty
   a_din_hold: assert property (p_din_hold) else $error("data moved while clock high");
   property p_sdo_edge;
      $changed(sdoOut) && !syncN |-> sinceRise <= 8'h05;
   endproperty
   a_sdo_edge: assert property (p_sdo_edge) else $error("output bit not after rise");
   // Inside a frame the enable only moves with the driven low level
   property p_oe_quiet;
      $changed(sdoOeN) && !syncN |-> sdoOeN == sdoOut;
   endproperty
   a_oe_quiet: assert property (p_oe_quiet) else $error("float changed inside frame");
endmodule
`default_nettype wire

// [verification/tb.sv]
// Bench joining host and device ends over the serial link.
// Drives the host Wishbone side; watches device outputs and the link.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin badCount++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb import rsco_pkg::*;;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic keepOtp = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] datI = 32'h0;
   logic [31:0] datO;
   logic ack;
   logic calEnable;
   logic progEn;
   logic [9:0] tapSel;
   logic [15:0] rx;
   int badCount = 0;
   int comparisons = 0;
   rsco_if link();
   rsco_host u_rsco_host (.ref_clk(ref_clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .dat_i(datI), .sel_i(4'hF), .dat_o(datO), .ack_o(ack), .link(link));
   rsco_device u_rsco_device (.ref_clk(ref_clk), .rst(rst), .link(link), .keepOtp(keepOtp),
      .tapSel(tapSel), .calEnable(calEnable), .otpProgramEnable(progEn));
   rsco_chk u_rsco_chk (.ref_clk(ref_clk), .rst(rst), .syncN(link.syncN), .sclk(link.sclk),
      .din(link.din), .sdoOut(link.sdoOut), .sdoOeN(link.sdoOeN));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic summarize;
      $display("comparisons=%0d mismatches=%0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datI <= d;
      // Only the watchdog ends a hung wait
      do begin
         @(posedge ref_clk);
      end while (ack !== 1'b1);
      q = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // One whole frame: start, poll busy, fetch what came back
   task automatic xfer(input logic [15:0] word, output logic [15:0] r);
      logic [31:0] q;
      int n;
      n = 0;
      wb(1'b1, HR_TX, {16'h0, word}, q);
      do begin
         wb(1'b0, HR_STATUS, 32'h0, q);
         n++;
      end while (q[0] !== 1'b0 && n < 200);
      if (n >= 200) badCount++;
      wb(1'b0, HR_RX, 32'h0, q);
      r = q[15:0];
      // Device acts a few clocks after select rises, past its synchronisers
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic doReset(input logic k);
      keepOtp <= k;
      rst <= 1'b1;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic t_regs;
      logic [31:0] q;
      wb(1'b0, HR_HALFDIV, 32'h0, q);
      `CHK(q[7:0], 8'h04)
      // Below the minimum would outrun the returning data, so it clamps
      wb(1'b1, HR_HALFDIV, 32'h2, q);
      wb(1'b0, HR_HALFDIV, 32'h0, q);
      `CHK(q[7:0], 8'h04)
      wb(1'b0, 4'h2, 32'h0, q);
      `CHK(q, 32'h0)
   endtask
   task automatic t_locked;
      `CHK(tapSel, 10'h200)
      `CHK(calEnable, 1'b1)
      `CHK(progEn, 1'b0)
      xfer(16'h0500, rx);
      `CHK(tapSel, 10'h200)
      xfer(16'h0C00, rx);
      xfer(16'h1800, rx);
      xfer(16'h2000, rx);
      `CHK(rx[5:0], 6'h00)
      xfer(16'h0000, rx);
      `CHK(rx[3:0], 4'h0)
   endtask
   task automatic t_store;
      xfer(16'h1C03, rx);
      `CHK(progEn, 1'b1)
      xfer(16'h0500, rx);
      `CHK(tapSel, 10'h100)
      xfer(16'h0800, rx);
      `CHK(rx, 16'h0500)
      xfer(16'h0C00, rx);
      `CHK(rx[9:0], 10'h100)
      xfer(16'h1800, rx);
      xfer(16'h1401, rx);
      `CHK(rx[5:0], 6'h01)
      xfer(16'h17C1, rx);
      `CHK(rx[9:0], 10'h100)
      xfer(16'h1400, rx);
      `CHK(rx[9:0], 10'h100)
      xfer(16'h2000, rx);
      `CHK(rx[9:0], 10'h000)
      xfer(16'h0000, rx);
      `CHK(rx[3:0], 4'hB)
   endtask
   task automatic t_modes;
      xfer(16'h1C07, rx);
      `CHK(calEnable, 1'b0)
      xfer(16'h0440, rx);
      `CHK(tapSel, 10'h040)
      xfer(16'h1000, rx);
      `CHK(tapSel, 10'h100)
      xfer(16'h0480, rx);
      xfer(16'h1C00, rx);
      `CHK(tapSel, 10'h100)
   endtask
   task automatic t_float;
      xfer(16'h8001, rx);
      xfer(16'h0000, rx);
      `CHK(link.sdoOeN, 1'b1)
      xfer(16'h0000, rx);
      `CHK(rx, 16'hFFFF)
      // Float ends at this frame; the driver returns at the next frame
      xfer(16'h0800, rx);
      xfer(16'h0000, rx);
      `CHK(rx, 16'h0100)
   endtask
   task automatic t_power;
      doReset(1'b1);
      `CHK(tapSel, 10'h100)
      `CHK(progEn, 1'b0)
      doReset(1'b0);
      `CHK(tapSel, 10'h200)
   endtask
   initial begin
      doReset(1'b0);
      t_regs();
      t_locked();
      t_store();
      t_modes();
      t_float();
      t_power();
      summarize();
   end
   // About twenty-five frames of some hundred and sixty clocks each; ample margin
   initial begin
      repeat (60000) @(posedge ref_clk);
      badCount++;
      summarize();
   end
endmodule
`default_nettype wire
